// *** logic/qr_valley_pkg.sv ***
// Constants, types and helpers for the quasi-resonant valley switching logic.
// Assumes one 25 MHz system clock; comparator levels arrive as digital pins.
// Behaviour
// - Gate rising edge starts 8 us clamp
// - Peak current reached ends the on-time
// - On-time over 50 us: stop, auto-restart
// - 3 us blanking after turn-off blocks restart
// - Core reset sensed by comparator edge
// - Early demag edge ignored, await next
// - Period clamp caps switching at 125 kHz
// - Valid demag edge sets the drive latch
// - Skip reset blocks demag edges
// - 8 us ringing timeout grants restart
// - Timeout restarts once skip reset releases
// - Feedback at skip level stops pulses
// - Resume above skip level plus hysteresis
// - Each skip release re-arms soft-start
// - Feedback clamped at skip level floor
// - Soft-start ramps setpoint over 5 ms
package qr_valley_pkg;

   // Clock rate and documented intervals in nanoseconds
   localparam int CLK_MHZ      = 25;
   localparam int CLAMP_NS     = 8000;
   localparam int MAXON_NS     = 50000;
   localparam int BLANK_NS     = 3000;
   localparam int TIMEOUT_NS   = 8000;
   localparam int SOFTSTART_NS = 5000000;
   localparam int RESTART_NS   = 1000000;

   // Least times round up, longest times round down
   function automatic int ns_up(input int ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction
   function automatic int ns_down(input int ns);
      return (ns * CLK_MHZ) / 1000;
   endfunction

   localparam int CLAMP_CYC     = ns_up(CLAMP_NS);
   localparam int MAXON_CYC     = ns_down(MAXON_NS);
   localparam int BLANK_CYC     = ns_up(BLANK_NS);
   localparam int TIMEOUT_CYC   = ns_up(TIMEOUT_NS);
   localparam int SOFTSTART_CYC = ns_up(SOFTSTART_NS);
   localparam int RESTART_CYC   = ns_up(RESTART_NS);

   // Setpoint word and levels
   localparam int         SET_W        = 8;
   localparam logic [7:0] SETPOINT_MAX = 8'hff;
   localparam logic [7:0] SETPOINT_RST = 8'h00;
   localparam logic [7:0] SKIP_LEVEL   = 8'h20;
   localparam logic [7:0] SKIP_HYST    = 8'h04;
   localparam int         CNT_W        = 24;

   // Synchronised comparator pair
   typedef struct packed {
      logic demag;
      logic current;
   } cmp_t;

   // Switching cycle states
   typedef enum logic [1:0] {
      ST_BLANK = 2'b00,
      ST_WAIT  = 2'b01,
      ST_ON    = 2'b10,
      ST_FAULT = 2'b11
   } state_t;

endpackage

// *** logic/qr_valley_switching_logic.sv ***
// Cycle-by-cycle gate control: valley restart, period clamp, on-time fault,
// blanking, ringing timeout, skip bursts and soft-start setpoint ramp.
// Assumes comparator pins are asynchronous and FEEDBACK_LEVEL is on SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
module qr_valley_switching_logic
   import qr_valley_pkg::*;
#(
   parameter int SOFTSTART_CYCLES = SOFTSTART_CYC,   // Shorten in simulation
   parameter int RESTART_CYCLES   = RESTART_CYC,     // Safe restart pause
   parameter logic [7:0] SKIP_THRESHOLD = SKIP_LEVEL,
   parameter logic [7:0] SKIP_HYSTERESIS = SKIP_HYST
) (
   // Clock and reset
   input  wire logic             SYS_CLK,
   input  wire logic             RST_N,
   // Analog comparator pins
   input  wire logic             DEMAG_CMP,
   input  wire logic             CURRENT_CMP,
   // Feedback loop word
   input  wire logic [SET_W-1:0] FEEDBACK_LEVEL,
   // Drive and status
   output var  logic             GATE_DRIVE_OUTPUT,
   output var  logic [SET_W-1:0] PEAK_SETPOINT,
   output var  logic             SKIP_ACTIVE,
   output var  logic             RESTART_FAULT
);

   // Soft-start step length, at least one cycle
   localparam int SS_STEP = (SOFTSTART_CYCLES / 256 > 0) ? SOFTSTART_CYCLES / 256 : 1;

   cmp_t             sync1;          // First stage, read only by sync2
   cmp_t             sync2;          // Usable comparator levels
   logic             demag_prev;     // Delayed demag for edge
   logic             demag_edge;     // Core reset edge pulse
   state_t           state;          // Cycle state
   state_t           next_state;
   logic [CNT_W-1:0] st_cnt;         // Per-state interval counter
   logic [CNT_W-1:0] next_st_cnt;
   logic [15:0]      clamp_cnt;      // Cycles since last set
   logic [15:0]      next_clamp_cnt;
   logic             clamp_done;     // Period clamp elapsed
   logic [15:0]      tmo_cnt;        // Cycles since last crossing
   logic [15:0]      next_tmo_cnt;
   logic             tmo_ok;         // Timeout restart permission
   logic             skip;           // Skip reset held
   logic             next_skip;
   logic             rearm;          // Soft-start restart pulse
   logic             next_rearm;
   logic             set_evt;        // Latch set this cycle
   logic [SET_W-1:0] ss_level;       // Soft-start ceiling
   logic [SET_W-1:0] next_ss_level;
   logic [CNT_W-1:0] ss_pre;         // Ramp prescaler
   logic [CNT_W-1:0] next_ss_pre;
   logic [SET_W-1:0] floor_fb;       // Feedback with skip floor
   logic [SET_W-1:0] next_setpoint;

   // Two-flop synchronisers and edge detection
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1      <= '0;
         sync2      <= '0;
         demag_prev <= 1'b0;
      end else begin
         sync1      <= '{demag: DEMAG_CMP, current: CURRENT_CMP};
         sync2      <= sync1;
         demag_prev <= sync2.demag;
      end
   end

   // Edge, not level, clocks the latch
   assign demag_edge = sync2.demag & ~demag_prev;
   assign clamp_done = (clamp_cnt == 16'(CLAMP_CYC));
   assign tmo_ok     = (tmo_cnt == 16'(TIMEOUT_CYC));

   // Skip comparator with hysteresis
   always_comb begin
      next_skip  = skip;
      next_rearm = 1'b0;
      if (!skip) begin
         if (FEEDBACK_LEVEL <= SKIP_THRESHOLD) begin
            next_skip = 1'b1;
         end
      end else if (FEEDBACK_LEVEL > SKIP_THRESHOLD + SKIP_HYSTERESIS) begin
         next_skip  = 1'b0;
         next_rearm = 1'b1;
      end
   end

   // Set only in wait, with clamp done, no skip, and a trigger
   assign set_evt = (state == ST_WAIT) && clamp_done && !skip
                    && (demag_edge || tmo_ok);

   // Cycle state machine next values
   always_comb begin
      next_state  = state;
      next_st_cnt = st_cnt + 1'b1;
      case (state)
         ST_BLANK: begin
            // Leakage ringing must never count as core reset
            if (st_cnt >= CNT_W'(BLANK_CYC - 1)) begin
               next_state  = ST_WAIT;
               next_st_cnt = '0;
            end
         end
         ST_WAIT: begin
            if (set_evt) begin
               next_state  = ST_ON;
               next_st_cnt = '0;
            end
         end
         ST_ON: begin
            if (st_cnt >= CNT_W'(MAXON_CYC - 1)) begin
               next_state  = ST_FAULT;
               next_st_cnt = '0;
            end else if (sync2.current || skip) begin
               next_state  = ST_BLANK;
               next_st_cnt = '0;
            end
         end
         ST_FAULT: begin
            // Auto-recovery after a quiet pause
            if (st_cnt >= CNT_W'(RESTART_CYCLES - 1)) begin
               next_state  = ST_BLANK;
               next_st_cnt = '0;
            end
         end
         default: begin
            next_state  = ST_BLANK;
            next_st_cnt = '0;
         end
      endcase
   end

   // Period clamp and ringing timeout counters
   always_comb begin
      next_clamp_cnt = clamp_cnt;
      next_tmo_cnt   = tmo_cnt;
      // Clamp restarts at every set, so on plus off is covered
      if (set_evt) begin
         next_clamp_cnt = '0;
      end else if (!clamp_done) begin
         next_clamp_cnt = clamp_cnt + 1'b1;
      end
      // Timeout only runs while off and past blanking
      if (state != ST_WAIT || demag_edge) begin
         next_tmo_cnt = '0;
      end else if (!tmo_ok) begin
         next_tmo_cnt = tmo_cnt + 1'b1;
      end
   end

   // Soft-start ramp and setpoint clamp
   always_comb begin
      next_ss_level = ss_level;
      next_ss_pre   = ss_pre;
      // Re-arm on the releasing edge itself, so the first burst pulse
      // already sees a low ceiling instead of one cycle at full level
      if (next_rearm || rearm || state == ST_FAULT) begin
         next_ss_level = SETPOINT_RST;
         next_ss_pre   = '0;
      end else if (ss_level != SETPOINT_MAX) begin
         if (ss_pre >= CNT_W'(SS_STEP - 1)) begin
            next_ss_pre   = '0;
            next_ss_level = ss_level + 1'b1;
         end else begin
            next_ss_pre = ss_pre + 1'b1;
         end
      end
      // Light load stops lowering the peak; skipping takes over
      floor_fb      = (FEEDBACK_LEVEL < SKIP_THRESHOLD) ? SKIP_THRESHOLD
                                                         : FEEDBACK_LEVEL;
      next_setpoint = (floor_fb < ss_level) ? floor_fb : ss_level;
   end

   // Register all groups; outputs straight from flops
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state             <= ST_BLANK;
         st_cnt            <= '0;
         clamp_cnt         <= 16'(CLAMP_CYC);
         tmo_cnt           <= '0;
         skip              <= 1'b0;
         rearm             <= 1'b0;
         ss_level          <= SETPOINT_RST;
         ss_pre            <= '0;
         GATE_DRIVE_OUTPUT <= 1'b0;
         PEAK_SETPOINT     <= SETPOINT_RST;
         SKIP_ACTIVE       <= 1'b0;
         RESTART_FAULT     <= 1'b0;
      end else begin
         state             <= next_state;
         st_cnt            <= next_st_cnt;
         clamp_cnt         <= next_clamp_cnt;
         tmo_cnt           <= next_tmo_cnt;
         skip              <= next_skip;
         rearm             <= next_rearm;
         ss_level          <= next_ss_level;
         ss_pre            <= next_ss_pre;
         GATE_DRIVE_OUTPUT <= (next_state == ST_ON);
         PEAK_SETPOINT     <= next_setpoint;
         SKIP_ACTIVE       <= next_skip;
         RESTART_FAULT     <= (next_state == ST_FAULT);
      end
   end

   // Helper counts for the checks below
   logic [15:0] low_cnt;    // Consecutive gate-low cycles
   logic [15:0] high_cnt;   // Consecutive gate-high cycles
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         low_cnt  <= 16'hffff;
         high_cnt <= '0;
      end else begin
         low_cnt  <= GATE_DRIVE_OUTPUT ? '0 : (low_cnt == 16'hffff ? low_cnt : low_cnt + 1'b1);
         high_cnt <= GATE_DRIVE_OUTPUT ? high_cnt + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   a_clamp_gates_set: assert property ($rose(GATE_DRIVE_OUTPUT) |-> $past(clamp_done))
      else $error("gate rose before period clamp elapsed");
   a_current_ends_on: assert property (
      (state == ST_ON && sync2.current) |=> !GATE_DRIVE_OUTPUT ##1 !GATE_DRIVE_OUTPUT)
      else $error("gate stayed high after peak current");
   a_max_on_limit: assert property (high_cnt <= 16'(MAXON_CYC))
      else $error("on-time exceeded the limit");
   a_fault_silent: assert property ($rose(RESTART_FAULT) |-> !GATE_DRIVE_OUTPUT[*8])
      else $error("pulses during safe restart");
   a_blank_window: assert property ($rose(GATE_DRIVE_OUTPUT) |-> $past(low_cnt) >= 16'(BLANK_CYC))
      else $error("restart inside blanking window");
   a_demag_sets: assert property (
      (state == ST_WAIT && demag_edge && clamp_done && !skip) |=> GATE_DRIVE_OUTPUT)
      else $error("valid demag edge did not set gate");
   a_skip_blocks: assert property ($rose(GATE_DRIVE_OUTPUT) |-> !$past(skip))
      else $error("gate set while skip reset held");
   a_timeout_grant: assert property (
      (state == ST_WAIT && tmo_ok && clamp_done && !skip) |=> GATE_DRIVE_OUTPUT)
      else $error("timeout permission did not restart");
   a_rearm_ramp: assert property (rearm |=> ss_level == SETPOINT_RST)
      else $error("soft-start not re-armed on skip release");
   a_setpoint_cap: assert property (PEAK_SETPOINT <= $past(ss_level))
      else $error("setpoint above soft-start ceiling");

   c_valley_start: cover property ($rose(GATE_DRIVE_OUTPUT) && $past(demag_edge));
   c_timeout_start: cover property ($rose(GATE_DRIVE_OUTPUT) && !$past(demag_edge));
   c_skip_burst: cover property ($fell(SKIP_ACTIVE) ##[1:400] $rose(GATE_DRIVE_OUTPUT));
   c_fault_entry: cover property ($rose(RESTART_FAULT));

endmodule // qr_valley_switching_logic
`default_nettype wire

// *** tb/qr_plant_model.sv ***
// Far side model: sensed switch current and auxiliary winding ringing.
// Assumes gate is sampled on clk; pins change just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module qr_plant_model (
   // Clock and gate
   input  wire logic        clk,
   input  wire logic        gate,
   // Bench knobs
   input  wire logic [15:0] cur_dly,   // On cycles to peak, 0 = open sense
   input  wire logic [15:0] ring_dly,  // Off cycles to first ring
   input  wire logic [15:0] ring_per,  // Ring period, never zero
   input  wire logic [15:0] ring_n,    // Rings before full damping
   // Comparator pins
   output var  logic        cur_cmp,
   output var  logic        demag_cmp
);
   logic [15:0] hi_cnt;  // Cycles with switch closed
   logic [15:0] lo_cnt;  // Cycles since switch opened
   logic [15:0] ph;      // Phase inside the ringing
   assign ph = lo_cnt - ring_dly;
   initial begin
      hi_cnt = 16'h0;
      lo_cnt = 16'h0;
      cur_cmp = 1'b0;
      demag_cmp = 1'b0;
   end
   // Open sense never trips, so a stuck on-time can be provoked
   always @(posedge clk) begin
      hi_cnt <= gate ? hi_cnt + 16'h1 : 16'h0;
      lo_cnt <= gate ? 16'h0 : lo_cnt + 16'h1;
      cur_cmp <= gate && cur_dly != 16'h0 && hi_cnt + 16'h1 >= cur_dly;
      // Short dips below ground, gone once the ringing has damped
      demag_cmp <= ring_n != 16'h0 && !gate && lo_cnt >= ring_dly
                   && ph % ring_per < 16'h3 && ph / ring_per < ring_n;
   end
endmodule // qr_plant_model
`default_nettype wire

// *** tb/qr_valley_switching_logic_tb.sv ***
// Self-checking bench for the valley switching logic and its plant model.
// Assumes shortened soft-start and restart pause; one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module qr_valley_switching_logic_tb;
   import qr_valley_pkg::*;
   logic             SYS_CLK, RST_N, DEMAG_CMP, CURRENT_CMP, GATE_DRIVE_OUTPUT;
   logic             SKIP_ACTIVE, RESTART_FAULT;
   logic [SET_W-1:0] FEEDBACK_LEVEL, PEAK_SETPOINT;
   logic [15:0]      cur_dly, ring_dly, ring_per, ring_n;  // Plant knobs
   int               fails = 0, compares = 0, cyc = 0, seed, hi_n, lo_n, e;
   int               on_q[$], off_q[$];  // Expected on and off times, -1 = free
   logic             prev_g;

   qr_valley_switching_logic #(.SOFTSTART_CYCLES(512), .RESTART_CYCLES(50)) dut_u (
      .SYS_CLK(SYS_CLK), .RST_N(RST_N), .DEMAG_CMP(DEMAG_CMP), .CURRENT_CMP(CURRENT_CMP),
      .FEEDBACK_LEVEL(FEEDBACK_LEVEL), .GATE_DRIVE_OUTPUT(GATE_DRIVE_OUTPUT),
      .PEAK_SETPOINT(PEAK_SETPOINT), .SKIP_ACTIVE(SKIP_ACTIVE), .RESTART_FAULT(RESTART_FAULT));
   qr_plant_model plant_u (.clk(SYS_CLK), .gate(GATE_DRIVE_OUTPUT), .cur_dly(cur_dly),
      .ring_dly(ring_dly), .ring_per(ring_per), .ring_n(ring_n), .cur_cmp(CURRENT_CMP),
      .demag_cmp(DEMAG_CMP));

   // Count one comparison, report a difference
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Sync delays leave a few cycles of slack on durations
   function automatic logic near(input int seen, input int exp);
      return (seen >= exp - 3) && (seen <= exp + 3);
   endfunction
   // Bounded wait until the gate shows the given level
   task automatic wait_gate(input logic v);
      int n;
      n = 0;
      while (GATE_DRIVE_OUTPUT !== v && n < 3000) begin
         @(posedge SYS_CLK);
         n++;
      end
   endtask
   // One pulse: set the plant, note the due times, wait it out
   task automatic pulse(input logic [15:0] d, input int off);
      cur_dly <= d;
      off_q.push_back(off);
      on_q.push_back(d == 16'h0 ? 1250 : d + 3);
      wait_gate(1'b1);
      wait_gate(1'b0);
   endtask
   // Counts, verdict, stop
   task automatic end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Clock
   initial begin
      SYS_CLK = 1'b0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   // Hang guard
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim;
      end
   end
   // Gate watcher: takes the oldest note at each edge of the gate
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         hi_n = 0;
         lo_n = 0;
      end else if (GATE_DRIVE_OUTPUT && !prev_g) begin
         chk(hi_n + lo_n >= 200, 1'b1);
         chk(lo_n >= 75, 1'b1);
         e = off_q.size() ? off_q.pop_front() : -1;
         if (e >= 0) chk(near(lo_n, e), 1'b1);
         hi_n = 1;
      end else if (!GATE_DRIVE_OUTPUT && prev_g) begin
         e = on_q.size() ? on_q.pop_front() : -1;
         if (e >= 0) chk(near(hi_n, e), 1'b1);
         lo_n = 1;
      end else if (GATE_DRIVE_OUTPUT) begin
         hi_n++;
      end else begin
         lo_n++;
      end
      prev_g = GATE_DRIVE_OUTPUT;
   end

   // Main sequence
   initial begin
      seed = 32'h3862;
      RST_N = 1'b0;
      FEEDBACK_LEVEL = 8'h80;
      cur_dly = 16'h1e;
      ring_dly = 16'h14;
      ring_per = 16'h2d;
      ring_n = 16'h0;
      repeat (8) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      // Damped ringing: every restart comes from the timeout
      repeat (3) begin
         FEEDBACK_LEVEL <= 8'h40 + 8'($random(seed) & 32'h7f);
         pulse(16'h14 + 16'($random(seed) & 32'h3f), 276);
      end
      chk(PEAK_SETPOINT, FEEDBACK_LEVEL);
      $display("test timeout restart done");
      // Ringing: early valleys fall in blanking or clamp, the fifth restarts
      ring_n <= 16'h6;
      pulse(16'h14, -1);
      pulse(16'h14, 205);
      $display("test valley restart done");
      // Skip in mid-pulse, ringing ignored, hysteresis, release
      cur_dly <= 16'h3c;
      off_q.push_back(-1);
      on_q.push_back(12);
      wait_gate(1'b1);
      repeat (9) @(posedge SYS_CLK);
      FEEDBACK_LEVEL <= 8'h10;
      repeat (2) @(posedge SYS_CLK);
      chk(SKIP_ACTIVE, 1'b1);
      repeat (600) @(posedge SYS_CLK);
      chk(GATE_DRIVE_OUTPUT, 1'b0);
      chk(PEAK_SETPOINT, SKIP_LEVEL);
      FEEDBACK_LEVEL <= 8'h24;
      repeat (5) @(posedge SYS_CLK);
      chk(SKIP_ACTIVE, 1'b1);
      off_q.push_back(-1);
      on_q.push_back(33);
      cur_dly <= 16'h1e;
      FEEDBACK_LEVEL <= 8'h25;
      repeat (3) @(posedge SYS_CLK);
      chk(SKIP_ACTIVE, 1'b0);
      chk(GATE_DRIVE_OUTPUT, 1'b1);
      chk(PEAK_SETPOINT <= 8'h02, 1'b1);
      wait_gate(1'b0);
      repeat (100) @(posedge SYS_CLK);
      chk(PEAK_SETPOINT, 8'h25);
      $display("test skip burst done");
      // Open current sense: on-time limit and safe restart pause
      pulse(16'h0, -1);
      repeat (40) @(posedge SYS_CLK);
      chk(RESTART_FAULT, 1'b1);
      chk(PEAK_SETPOINT, 8'h00);
      repeat (20) @(posedge SYS_CLK);
      chk(RESTART_FAULT, 1'b0);
      $display("test on-time fault done");
      end_sim;
   end
endmodule // qr_valley_switching_logic_tb
`default_nettype wire
